//--- logic/priority_binary_point_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "bpr_defs.svh"
module priority_binary_point_regs
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  input wire logic ACC_VALID,
  input wire logic ACC_WRITE,
  input wire logic ACC_GROUP1,
  input wire logic [1:0] ACC_LEVEL,
  input wire logic ACC_NONSECURE,
  input wire logic [63:0] ACC_WDATA,
  input wire logic HIGHEST_PRESENT,
  input wire logic HIGHEST_64BIT,
  input wire logic HYP_PRESENT_64BIT,
  input wire logic SECURE_HYP_ENABLE,
  input wire logic [2:0] SYSREG_IFACE_ENABLE,
  input wire logic HYP_TRAP_ALL_GROUP0,
  input wire logic HYP_TRAP_ALL_GROUP1,
  input wire logic IRQ_ROUTE_TO_HYP,
  input wire logic FIQ_ROUTE_TO_HYP,
  input wire logic IRQ_ROUTE_TO_MONITOR,
  input wire logic FIQ_ROUTE_TO_MONITOR,
  input wire logic SECURE_COMMON_SPLIT_CTL,
  input wire logic NONSECURE_COMMON_SPLIT_CTL,
  input wire logic LEVEL1_COMMON_SPLIT_CTL,
  input wire logic [2:0] PRIORITY_BIT_COUNT,
  output logic RD_VALID,
  output logic [63:0] RD_DATA,
  output logic WR_DONE,
  output logic TRAP_VALID,
  output logic [1:0] TRAP_LEVEL,
  output logic [5:0] TRAP_CLASS,
  output logic UNDEF_VALID,
  output logic [2:0] VM_CTRL_GROUP0_SPLIT,
  output logic [2:0] VM_CTRL_GROUP1_SPLIT,
  output logic [7:0] GROUP0_PRIO_MASK,
  output logic [7:0] GROUP1_S_PRIO_MASK,
  output logic [7:0] GROUP1_NS_PRIO_MASK
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [2:0] split0_ff;
  logic [2:0] split1_s_ff;
  logic [2:0] split1_ns_ff;
  logic [2:0] min0;
  logic [2:0] min1_ns;
  logic [2:0] alias_val;
  logic [2:0] wr_val;
  logic [2:0] tgt_min;
  logic [2:0] rd_val;
  logic hyp_en;
  logic trap_all;
  logic route_hyp;
  logic route_mon;
  logic ns_common;
  logic [1:0] trap_lvl;
  bpr_pkg::act_type act;
  bpr_pkg::tgt_type tgt;
  logic [2:0] eff_g1_s;
  logic [2:0] eff_g1_ns;
  logic [7:0] nxt_mask0;
  logic [7:0] nxt_mask1_s;
  logic [7:0] nxt_mask1_ns;

  // ----------------------------------------
  // Minimum split values
  // ----------------------------------------
  // Minimum from bit count
  assign min0 = `BPR_SPLIT_MAX - PRIORITY_BIT_COUNT;
  assign min1_ns = (min0 == `BPR_SPLIT_MAX) ? `BPR_SPLIT_MAX : min0 + `BPR_SPLIT_ONE;
  assign alias_val = (split0_ff == `BPR_SPLIT_MAX) ? `BPR_SPLIT_MAX : split0_ff + `BPR_SPLIT_ONE;

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  // Secure hyp level only counts when enabled for the Secure state
  assign hyp_en = HYP_PRESENT_64BIT & (ACC_NONSECURE | SECURE_HYP_ENABLE);
  assign trap_all = ACC_GROUP1 ? HYP_TRAP_ALL_GROUP1 : HYP_TRAP_ALL_GROUP0;
  assign route_hyp = ACC_GROUP1 ? IRQ_ROUTE_TO_HYP : FIQ_ROUTE_TO_HYP;
  assign route_mon = HIGHEST_PRESENT & HIGHEST_64BIT & (ACC_GROUP1 ? IRQ_ROUTE_TO_MONITOR : FIQ_ROUTE_TO_MONITOR);
  // Level-1 control stands in without monitor level
  assign ns_common = HIGHEST_PRESENT ? NONSECURE_COMMON_SPLIT_CTL : LEVEL1_COMMON_SPLIT_CTL;

  always_comb
  begin
    act = bpr_pkg::ACT_PHYS;
    tgt = bpr_pkg::TGT_G0;
    trap_lvl = `BPR_LVL_1;
    unique case (ACC_LEVEL)
      `BPR_LVL_0:
      begin
        act = bpr_pkg::ACT_UNDEF;
      end
      `BPR_LVL_1:
      begin
        if (!SYSREG_IFACE_ENABLE[0])
        begin
          act = bpr_pkg::ACT_TRAP;
          trap_lvl = `BPR_LVL_1;
        end
        else if (hyp_en && trap_all)
        begin
          act = bpr_pkg::ACT_TRAP;
          trap_lvl = `BPR_LVL_2;
        end
        else if (hyp_en && route_hyp)
        begin
          act = bpr_pkg::ACT_VIRT;
          tgt = ACC_GROUP1 ? bpr_pkg::TGT_VG1 : bpr_pkg::TGT_VG0;
        end
        else if (route_mon)
        begin
          act = bpr_pkg::ACT_TRAP;
          trap_lvl = `BPR_LVL_3;
        end
      end
      `BPR_LVL_2:
      begin
        if (!SYSREG_IFACE_ENABLE[1])
        begin
          act = bpr_pkg::ACT_TRAP;
          trap_lvl = `BPR_LVL_2;
        end
        else if (route_mon)
        begin
          act = bpr_pkg::ACT_TRAP;
          trap_lvl = `BPR_LVL_3;
        end
      end
      `BPR_LVL_3:
      begin
        if (!SYSREG_IFACE_ENABLE[2])
        begin
          act = bpr_pkg::ACT_TRAP;
          trap_lvl = `BPR_LVL_3;
        end
      end
    endcase
    if (act == bpr_pkg::ACT_PHYS && ACC_GROUP1)
    begin
      if (HIGHEST_PRESENT && !ACC_NONSECURE)
      begin
        // Secure common alias onto group 0
        tgt = (SECURE_COMMON_SPLIT_CTL && ACC_LEVEL == `BPR_LVL_1) ? bpr_pkg::TGT_G0 : bpr_pkg::TGT_G1_S;
      end
      else if (ns_common && ACC_LEVEL != `BPR_LVL_3)
      begin
        act = bpr_pkg::ACT_ALIAS;
      end
      else
      begin
        tgt = bpr_pkg::TGT_G1_NS;
      end
    end
  end

  // ----------------------------------------
  // Write value with clamping
  // ----------------------------------------
  always_comb
  begin
    unique case (tgt)
      bpr_pkg::TGT_G1_NS: tgt_min = min1_ns;
      bpr_pkg::TGT_G0, bpr_pkg::TGT_G1_S: tgt_min = min0;
      default: tgt_min = 3'h0;
    endcase
  end

  assign wr_val = (ACC_WDATA[2:0] < tgt_min) ? tgt_min : ACC_WDATA[2:0];

  always_comb
  begin
    unique case (tgt)
      bpr_pkg::TGT_G1_S: rd_val = split1_s_ff;
      bpr_pkg::TGT_G1_NS: rd_val = split1_ns_ff;
      bpr_pkg::TGT_VG0: rd_val = VM_CTRL_GROUP0_SPLIT;
      bpr_pkg::TGT_VG1: rd_val = VM_CTRL_GROUP1_SPLIT;
      default: rd_val = split0_ff;
    endcase
  end

  // ----------------------------------------
  // Physical split storage
  // ----------------------------------------
  // Reset value is BPR_RESET_VALUE (3'h7); software must program before use
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      split0_ff <= `BPR_RESET_VALUE;
      split1_s_ff <= `BPR_RESET_VALUE;
      split1_ns_ff <= `BPR_RESET_VALUE;
    end
    else if (CLK_EN && ACC_VALID && ACC_WRITE && act == bpr_pkg::ACT_PHYS)
    begin
      unique case (tgt)
        bpr_pkg::TGT_G1_S: split1_s_ff <= wr_val;
        bpr_pkg::TGT_G1_NS: split1_ns_ff <= wr_val;
        default: split0_ff <= wr_val;
      endcase
    end
  end

  // ----------------------------------------
  // Virtual split fields
  // ----------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      VM_CTRL_GROUP0_SPLIT <= `BPR_RESET_VALUE;
      VM_CTRL_GROUP1_SPLIT <= `BPR_RESET_VALUE;
    end
    else if (CLK_EN && ACC_VALID && ACC_WRITE && act == bpr_pkg::ACT_VIRT)
    begin
      if (tgt == bpr_pkg::TGT_VG1)
        VM_CTRL_GROUP1_SPLIT <= wr_val;
      else
        VM_CTRL_GROUP0_SPLIT <= wr_val;
    end
  end

  // ----------------------------------------
  // Access response
  // ----------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      RD_VALID <= 1'b0;
      RD_DATA <= 64'h0000_0000_0000_0000;
      WR_DONE <= 1'b0;
      TRAP_VALID <= 1'b0;
      TRAP_LEVEL <= `BPR_LVL_0;
      TRAP_CLASS <= 6'h00;
      UNDEF_VALID <= 1'b0;
    end
    else if (CLK_EN)
    begin
      RD_VALID <= 1'b0;
      WR_DONE <= 1'b0;
      TRAP_VALID <= 1'b0;
      UNDEF_VALID <= 1'b0;
      if (ACC_VALID)
      begin
        unique case (act)
          bpr_pkg::ACT_UNDEF:
          begin
            UNDEF_VALID <= 1'b1;
          end
          bpr_pkg::ACT_TRAP:
          begin
            TRAP_VALID <= 1'b1;
            TRAP_LEVEL <= trap_lvl;
            TRAP_CLASS <= `BPR_TRAP_CLASS;
          end
          bpr_pkg::ACT_ALIAS:
          begin
            // Level 1 and 2 alias read, write dropped
            RD_VALID <= !ACC_WRITE;
            WR_DONE <= ACC_WRITE;
            if (!ACC_WRITE)
              RD_DATA <= {61'h0, alias_val};
          end
          default:
          begin
            RD_VALID <= !ACC_WRITE;
            WR_DONE <= ACC_WRITE;
            if (!ACC_WRITE)
              RD_DATA <= {61'h0, rd_val};
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Group priority masks
  // ----------------------------------------
  // Common control makes group 1 preempt by the group 0 split
  assign eff_g1_s = (HIGHEST_PRESENT && SECURE_COMMON_SPLIT_CTL) ? split0_ff : split1_s_ff;
  assign eff_g1_ns = ns_common ? split0_ff : split1_ns_ff;

  generate
    for (genvar i = 0; i < `BPR_PRIO_W; i++)
    begin : g_mask
      // Bit i is group priority when above the split
      assign nxt_mask0[i] = 3'(i) > split0_ff;
      assign nxt_mask1_s[i] = 3'(i) > eff_g1_s;
      assign nxt_mask1_ns[i] = 3'(i) > eff_g1_ns;
    end
  endgenerate

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      GROUP0_PRIO_MASK <= 8'h00;
      GROUP1_S_PRIO_MASK <= 8'h00;
      GROUP1_NS_PRIO_MASK <= 8'h00;
    end
    else if (CLK_EN)
    begin
      GROUP0_PRIO_MASK <= nxt_mask0;
      GROUP1_S_PRIO_MASK <= nxt_mask1_s;
      GROUP1_NS_PRIO_MASK <= nxt_mask1_ns;
    end
  end

endmodule
`default_nettype wire

//--- logic/bpr_defs.svh
`ifndef BPR_DEFS_SVH
`define BPR_DEFS_SVH

// ----------------------------------------
// Field layout and values
// ----------------------------------------
`define BPR_DATA_W 64
`define BPR_FIELD_W 3
`define BPR_SPLIT_MAX 3'h7
`define BPR_SPLIT_ONE 3'h1
`define BPR_RESET_VALUE 3'h7
`define BPR_TRAP_CLASS 6'h18
`define BPR_PRIO_W 8

// ----------------------------------------
// Privilege level codes
// ----------------------------------------
`define BPR_LVL_0 2'h0
`define BPR_LVL_1 2'h1
`define BPR_LVL_2 2'h2
`define BPR_LVL_3 2'h3

`endif

//--- logic/bpr_pkg.sv
package bpr_pkg;

  // ----------------------------------------
  // Outcome of a decoded access
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    ACT_UNDEF = 3'b000,
    ACT_TRAP = 3'b001,
    ACT_PHYS = 3'b010,
    ACT_VIRT = 3'b011,
    ACT_ALIAS = 3'b100
  } act_type;

  // ----------------------------------------
  // Storage selected by an access
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    TGT_G0 = 3'b000,
    TGT_G1_S = 3'b001,
    TGT_G1_NS = 3'b010,
    TGT_VG0 = 3'b011,
    TGT_VG1 = 3'b100
  } tgt_type;

endpackage

//--- test/bpr_checker_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checks
// ----------------------------------------
module bpr_checker
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  input wire logic ACC_VALID,
  input wire logic ACC_GROUP1,
  input wire logic [1:0] ACC_LEVEL,
  input wire logic ACC_NONSECURE,
  input wire logic HIGHEST_PRESENT,
  input wire logic HIGHEST_64BIT,
  input wire logic HYP_PRESENT_64BIT,
  input wire logic [2:0] SYSREG_IFACE_ENABLE,
  input wire logic HYP_TRAP_ALL_GROUP0,
  input wire logic IRQ_ROUTE_TO_MONITOR,
  input wire logic FIQ_ROUTE_TO_MONITOR,
  input wire logic RD_VALID,
  input wire logic [63:0] RD_DATA,
  input wire logic TRAP_VALID,
  input wire logic [1:0] TRAP_LEVEL,
  input wire logic [5:0] TRAP_CLASS,
  input wire logic UNDEF_VALID,
  input wire logic [7:0] GROUP0_PRIO_MASK
);
  wire logic t = ACC_VALID && CLK_EN;
  wire logic mon = HIGHEST_PRESENT && HIGHEST_64BIT;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  a_upper_zero:
    assert property (RD_VALID |-> RD_DATA[63:3] == 61'h0) else $error("read upper bits set");
  a_mask_shape:
    assert property (!GROUP0_PRIO_MASK[0] && ((GROUP0_PRIO_MASK << 1) & ~GROUP0_PRIO_MASK) == 8'h00)
    else $error("group mask not top aligned");
  a_level0_undef:
    assert property (t && ACC_LEVEL == 2'h0 |=> UNDEF_VALID) else $error("level 0 not undef");
  a_iface_trap:
    assert property (t && ACC_LEVEL == 2'h1 && !SYSREG_IFACE_ENABLE[0] |=> TRAP_VALID && TRAP_LEVEL == 2'h1)
    else $error("disabled interface no trap");
  a_trap_class:
    assert property (TRAP_VALID |-> TRAP_CLASS == 6'h18) else $error("bad trap class");
  a_trap_all:
    assert property (t && ACC_LEVEL == 2'h1 && SYSREG_IFACE_ENABLE[0] && HYP_PRESENT_64BIT && ACC_NONSECURE
      && HYP_TRAP_ALL_GROUP0 && !ACC_GROUP1 |=> TRAP_VALID && TRAP_LEVEL == 2'h2) else $error("no hyp trap");
  a_fiq_mon:
    assert property (t && ACC_LEVEL == 2'h2 && SYSREG_IFACE_ENABLE[1] && mon && FIQ_ROUTE_TO_MONITOR
      && !ACC_GROUP1 |=> TRAP_VALID && TRAP_LEVEL == 2'h3) else $error("no monitor trap g0");
  a_irq_mon:
    assert property (t && ACC_LEVEL == 2'h2 && SYSREG_IFACE_ENABLE[1] && mon && IRQ_ROUTE_TO_MONITOR
      && ACC_GROUP1 |=> TRAP_VALID && TRAP_LEVEL == 2'h3) else $error("no monitor trap g1");
endmodule
bind priority_binary_point_regs bpr_checker i_chk (.*);
`default_nettype wire

//--- test/core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Core issuing accesses
// ----------------------------------------
module core_model
(
  input wire logic clk,
  output logic v,
  output logic w,
  output logic g1,
  output logic [1:0] lvl,
  output logic [63:0] d
);
  initial
  begin
    v = 1'h0;
    w = 1'h0;
    g1 = 1'h0;
    lvl = 2'h1;
    d = 64'h0;
  end
  // One access, then data inverted so stale values never match
  task automatic acc(input logic iw, input logic ig, input logic [1:0] il, input logic [63:0] id);
    @(negedge clk);
    v = 1'h1;
    w = iw;
    g1 = ig;
    lvl = il;
    d = id;
    @(negedge clk);
    v = 1'h0;
    d = ~id;
  endtask
endmodule
`default_nettype wire

//--- test/tb_priority_binary_point_regs.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Scenario bench
// ----------------------------------------
module tb_priority_binary_point_regs;
  logic CORE_CLK = 1'h0;
  logic RST = 1'h1;
  logic CLK_EN = 1'h1;
  logic ACC_VALID, ACC_WRITE, ACC_GROUP1;
  logic [1:0] ACC_LEVEL, TRAP_LEVEL;
  logic [63:0] ACC_WDATA, RD_DATA;
  logic ACC_NONSECURE = 1'h1;
  logic HIGHEST_PRESENT = 1'h1;
  logic HIGHEST_64BIT = 1'h1;
  logic HYP_PRESENT_64BIT = 1'h0, SECURE_HYP_ENABLE = 1'h0, HYP_TRAP_ALL_GROUP0 = 1'h0, HYP_TRAP_ALL_GROUP1 = 1'h0;
  logic IRQ_ROUTE_TO_HYP = 1'h0, FIQ_ROUTE_TO_HYP = 1'h0, IRQ_ROUTE_TO_MONITOR = 1'h0, FIQ_ROUTE_TO_MONITOR = 1'h0;
  logic SECURE_COMMON_SPLIT_CTL = 1'h0, NONSECURE_COMMON_SPLIT_CTL = 1'h0, LEVEL1_COMMON_SPLIT_CTL = 1'h0;
  logic [2:0] SYSREG_IFACE_ENABLE = 3'h7;
  logic [2:0] PRIORITY_BIT_COUNT = 3'h4;
  logic RD_VALID, WR_DONE, TRAP_VALID, UNDEF_VALID;
  logic [5:0] TRAP_CLASS;
  logic [2:0] VM_CTRL_GROUP0_SPLIT, VM_CTRL_GROUP1_SPLIT;
  logic [7:0] GROUP0_PRIO_MASK, GROUP1_S_PRIO_MASK, GROUP1_NS_PRIO_MASK;
  int error_cnt = 0;
  int comparisons = 0;
  always #20 CORE_CLK = ~CORE_CLK;
  priority_binary_point_regs i_dut (.*);
  core_model i_core (.clk(CORE_CLK), .v(ACC_VALID), .w(ACC_WRITE), .g1(ACC_GROUP1), .lvl(ACC_LEVEL), .d(ACC_WDATA));
  task automatic wrap_up;
    if (error_cnt == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    comparisons++;
    if (s !== e)
    begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic rd(input logic g, input logic [1:0] l, input logic [2:0] e);
    i_core.acc(1'h0, g, l, 64'h0);
    chk("read valid", 1'h1, RD_VALID);
    chk("read data", {61'h0, e}, RD_DATA);
  endtask
  task automatic wr(input logic g, input logic [1:0] l, input logic [63:0] d);
    i_core.acc(1'h1, g, l, d);
    chk("write done", 1'h1, WR_DONE);
  endtask
  task automatic tr(input logic g, input logic [1:0] l, input logic [1:0] e);
    i_core.acc(1'h0, g, l, 64'h0);
    chk("trap valid", 1'h1, TRAP_VALID);
    chk("trap level", e, TRAP_LEVEL);
  endtask
  task automatic s_clamp;
    wr(1'h0, 2'h1, 64'h0);
    rd(1'h0, 2'h1, 3'h7 - PRIORITY_BIT_COUNT);
    wr(1'h0, 2'h1, 64'hFFFF_FFFF_FFFF_FFFD);
    rd(1'h0, 2'h1, 3'h5);
    chk("group0 mask", 8'hC0, GROUP0_PRIO_MASK);
    wr(1'h1, 2'h1, 64'h0);
    rd(1'h1, 2'h1, 3'h7 - PRIORITY_BIT_COUNT + 3'h1);
    chk("ns group1 mask", 8'hE0, GROUP1_NS_PRIO_MASK);
    ACC_NONSECURE = 1'h0;
    wr(1'h1, 2'h1, 64'h0);
    rd(1'h1, 2'h1, 3'h3);
    chk("s group1 mask", 8'hF0, GROUP1_S_PRIO_MASK);
    ACC_NONSECURE = 1'h1;
    rd(1'h1, 2'h1, 3'h4);
  endtask
  task automatic s_alias;
    NONSECURE_COMMON_SPLIT_CTL = 1'h1;
    rd(1'h1, 2'h1, 3'h6);
    rd(1'h1, 2'h2, 3'h6);
    wr(1'h1, 2'h1, 64'h0);
    rd(1'h0, 2'h1, 3'h5);
    wr(1'h0, 2'h1, 64'h7);
    rd(1'h1, 2'h2, 3'h7);
    IRQ_ROUTE_TO_MONITOR = 1'h1;
    tr(1'h1, 2'h1, 2'h3);
    tr(1'h1, 2'h2, 2'h3);
    IRQ_ROUTE_TO_MONITOR = 1'h0;
    NONSECURE_COMMON_SPLIT_CTL = 1'h0;
    rd(1'h1, 2'h1, 3'h4);
  endtask
  task automatic s_secure;
    ACC_NONSECURE = 1'h0;
    SECURE_COMMON_SPLIT_CTL = 1'h1;
    wr(1'h1, 2'h1, 64'h6);
    rd(1'h0, 2'h1, 3'h6);
    SECURE_COMMON_SPLIT_CTL = 1'h0;
    rd(1'h1, 2'h1, 3'h3);
    ACC_NONSECURE = 1'h1;
  endtask
  task automatic s_virt;
    HYP_PRESENT_64BIT = 1'h1;
    FIQ_ROUTE_TO_HYP = 1'h1;
    wr(1'h0, 2'h1, 64'h1);
    chk("virtual group0", 3'h1, VM_CTRL_GROUP0_SPLIT);
    rd(1'h0, 2'h2, 3'h6);
    FIQ_ROUTE_TO_HYP = 1'h0;
    IRQ_ROUTE_TO_HYP = 1'h1;
    NONSECURE_COMMON_SPLIT_CTL = 1'h1;
    wr(1'h1, 2'h1, 64'h2);
    chk("virtual group1", 3'h2, VM_CTRL_GROUP1_SPLIT);
    rd(1'h1, 2'h2, 3'h7);
    ACC_NONSECURE = 1'h0;
    SECURE_HYP_ENABLE = 1'h1;
    SECURE_COMMON_SPLIT_CTL = 1'h1;
    wr(1'h1, 2'h1, 64'h5);
    chk("virtual group1", 3'h5, VM_CTRL_GROUP1_SPLIT);
    SECURE_COMMON_SPLIT_CTL = 1'h0;
    SECURE_HYP_ENABLE = 1'h0;
    ACC_NONSECURE = 1'h1;
    IRQ_ROUTE_TO_MONITOR = 1'h1;
    tr(1'h1, 2'h2, 2'h3);
    IRQ_ROUTE_TO_MONITOR = 1'h0;
    IRQ_ROUTE_TO_HYP = 1'h0;
    NONSECURE_COMMON_SPLIT_CTL = 1'h0;
  endtask
  task automatic s_traps;
    SYSREG_IFACE_ENABLE = 3'h6;
    tr(1'h0, 2'h1, 2'h1);
    chk("trap class", 6'h18, TRAP_CLASS);
    SYSREG_IFACE_ENABLE = 3'h5;
    tr(1'h1, 2'h2, 2'h2);
    SYSREG_IFACE_ENABLE = 3'h3;
    tr(1'h0, 2'h3, 2'h3);
    SYSREG_IFACE_ENABLE = 3'h7;
    HYP_TRAP_ALL_GROUP0 = 1'h1;
    tr(1'h0, 2'h1, 2'h2);
    rd(1'h1, 2'h1, 3'h4);
    HYP_TRAP_ALL_GROUP0 = 1'h0;
    HYP_PRESENT_64BIT = 1'h0;
    FIQ_ROUTE_TO_MONITOR = 1'h1;
    tr(1'h0, 2'h1, 2'h3);
    tr(1'h0, 2'h2, 2'h3);
    rd(1'h0, 2'h3, 3'h6);
    FIQ_ROUTE_TO_MONITOR = 1'h0;
    i_core.acc(1'h0, 1'h0, 2'h0, 64'h0);
    chk("undef", 1'h1, UNDEF_VALID);
  endtask
  task automatic s_nomon;
    HIGHEST_PRESENT = 1'h0;
    LEVEL1_COMMON_SPLIT_CTL = 1'h1;
    rd(1'h1, 2'h1, 3'h7);
    wr(1'h0, 2'h1, 64'h0);
    rd(1'h1, 2'h2, 3'h4);
    HYP_PRESENT_64BIT = 1'h1;
    IRQ_ROUTE_TO_HYP = 1'h1;
    wr(1'h1, 2'h1, 64'h3);
    chk("virtual group1", 3'h3, VM_CTRL_GROUP1_SPLIT);
  endtask
  // Clock enable low must swallow an access and keep the stored split
  task automatic s_freeze;
    @(negedge CORE_CLK);
    CLK_EN = 1'h0;
    i_core.acc(1'h1, 1'h0, 2'h1, 64'h6);
    chk("frozen write done", 1'h0, WR_DONE);
    CLK_EN = 1'h1;
    rd(1'h0, 2'h1, 3'h3);
  endtask
  initial
  begin
    repeat (5) @(negedge CORE_CLK);
    RST = 1'h0;
    s_clamp;
    s_alias;
    s_secure;
    s_virt;
    s_traps;
    s_nomon;
    s_freeze;
    wrap_up;
  end
  // Watchdog: a hung access ends the run as a mismatch
  initial
  begin
    repeat (3000) @(posedge CORE_CLK);
    error_cnt++;
    wrap_up;
  end
endmodule
`default_nettype wire
